/* hdl/aux_cfg_if.sv */
`default_nettype none
interface aux_cfg_if;
    logic [31:0] ns_cfg;
    logic [31:0] s_cfg;
    modport cfg_src (output ns_cfg, output s_cfg);
    modport cfg_snk (input ns_cfg, input s_cfg);
endinterface
`default_nettype wire

/* hdl/aux_cfg_pkg.sv */
`default_nettype none
package aux_cfg_pkg;
    localparam int AXI_AW = 16;
    localparam logic [AXI_AW-1:0] ACR_OFFSET = 16'h0010;
    localparam int BIT_CTX_LOCK = 26;
    localparam int BIT_DEP_OFF_BUF = 25;
    localparam int BIT_DEP_OFF_CTL = 24;
    localparam int BIT_STREAM_CTX_BYP = 10;
    localparam int BIT_XLAT_OFF_BYP = 9;
    localparam int BIT_UNMATCHED_BYP = 8;
    localparam int BIT_S2_WALK_CACHE2 = 3;
    // writable bits per bank; everything else is reserved and reads zero
    localparam logic [31:0] NS_WR_MASK = 32'h0700_0708;
    localparam logic [31:0] S_WR_MASK = 32'h0700_0700;
    localparam logic [31:0] NS_RESET = 32'h0400_0008;
    localparam logic [31:0] S_RESET = 32'h0400_0000;
    localparam int PAGE_SHIFT = 12;
    localparam int BYPASS_SAVE_CYC = 6;
    localparam int LAT_MISS_DEF = 10;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [1:0] {
        TXN_TRANSLATE = 2'b00,
        TXN_STREAM_CTX_BYP = 2'b01,
        TXN_XLAT_OFF_BYP = 2'b11,
        TXN_UNMATCHED_BYP = 2'b10
    } txn_kind_e;

    typedef enum logic [1:0] {
        LAT_IDLE = 2'b00,
        LAT_COUNT = 2'b01,
        LAT_DONE = 2'b11
    } lat_state_e;

    function automatic logic [31:0] merge_write(input logic [31:0] old_val,
                                                input logic [31:0] wdata,
                                                input logic [3:0] wstrb,
                                                input logic [31:0] mask);
        logic [31:0] merged;
        merged = old_val;
        for (int i = 0; i < 4; i++) begin
            if (wstrb[i]) begin
                merged[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return (merged & mask) | (old_val & ~mask);
    endfunction
endpackage
`default_nettype wire

/* hdl/bypass_cache_ctrl.sv */
`default_nettype none
module bypass_cache_ctrl
    import aux_cfg_pkg::*;
#(
    parameter int LAT_MISS = LAT_MISS_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    aux_cfg_if.cfg_snk cfg,
    input wire logic txn_valid,
    output logic txn_ready,
    input wire logic txn_secure,
    input wire logic [1:0] txn_kind,
    input wire logic txn_bypass_hit,
    output logic alloc_entry,
    output logic txn_done
);
    localparam int CNT_W = $clog2(LAT_MISS + 1);
    localparam logic [CNT_W-1:0] MISS_CNT = CNT_W'(LAT_MISS);
    // a hit never drops below one cycle of latency
    localparam logic [CNT_W-1:0] HIT_CNT =
        CNT_W'((LAT_MISS > BYPASS_SAVE_CYC) ? LAT_MISS - BYPASS_SAVE_CYC : 1);

    lat_state_e state_ff;
    lat_state_e nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [31:0] bank_cfg;
    logic kind_cached;
    logic take;
    logic alloc_ff;

    assign bank_cfg = txn_secure ? cfg.s_cfg : cfg.ns_cfg;
    assign txn_ready = (state_ff == LAT_IDLE);
    assign take = txn_valid && txn_ready;
    assign kind_cached =
        (txn_kind == TXN_STREAM_CTX_BYP && bank_cfg[BIT_STREAM_CTX_BYP])   // see RULE6
        || (txn_kind == TXN_XLAT_OFF_BYP && bank_cfg[BIT_XLAT_OFF_BYP])    // see RULE8
        || (txn_kind == TXN_UNMATCHED_BYP && bank_cfg[BIT_UNMATCHED_BYP]); // see RULE11

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            LAT_IDLE: begin
                if (take) begin
                    nxt_state = LAT_COUNT;
                end
            end
            LAT_COUNT: begin
                if (cnt_ff == CNT_W'(1)) begin
                    nxt_state = LAT_DONE;
                end
            end
            LAT_DONE: nxt_state = LAT_IDLE;
            default: nxt_state = LAT_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= LAT_IDLE;
            cnt_ff <= '0;
            alloc_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            alloc_ff <= take && !txn_bypass_hit && kind_cached; // see RULE7
            if (take) begin
                cnt_ff <= (txn_bypass_hit && txn_kind != TXN_TRANSLATE)
                    ? HIT_CNT : MISS_CNT; // see RULE9
            end else if (state_ff == LAT_COUNT) begin
                cnt_ff <= cnt_ff - CNT_W'(1);
            end
        end
    end

    assign alloc_entry = alloc_ff;
    assign txn_done = (state_ff == LAT_DONE);
endmodule // bypass_cache_ctrl
`default_nettype wire

/* hdl/page_dep_check.sv */
`default_nettype none
module page_dep_check
    import aux_cfg_pkg::*;
#(
    parameter int SID_W = 16,
    parameter int ADDR_W = 48
) (
    input wire logic aclk,
    input wire logic aresetn,
    aux_cfg_if.cfg_snk cfg,
    input wire logic txn_valid,
    input wire logic txn_secure,
    input wire logic [SID_W-1:0] txn_stream_identifier,
    input wire logic [ADDR_W-1:0] txn_addr,
    input wire logic walk_active,
    input wire logic walk_secure,
    input wire logic [SID_W-1:0] walk_stream_identifier,
    input wire logic [ADDR_W-1:0] walk_addr,
    output logic dep_wait_buffer_unit,
    output logic dep_wait_control_unit
);
    logic [31:0] bank_cfg;
    logic same_region;
    logic check_buf_on;
    logic check_ctl_on;
    logic dep_buf_ff;
    logic dep_ctl_ff;

    // banked bits follow the security of the transaction
    assign bank_cfg = txn_secure ? cfg.s_cfg : cfg.ns_cfg;
    assign same_region = walk_active && txn_valid
        && (txn_addr[ADDR_W-1:PAGE_SHIFT] == walk_addr[ADDR_W-1:PAGE_SHIFT])
        && (txn_stream_identifier == walk_stream_identifier)
        && (txn_secure == walk_secure); // see RULE2
    assign check_buf_on = !bank_cfg[BIT_DEP_OFF_BUF]; // see RULE3
    assign check_ctl_on = !bank_cfg[BIT_DEP_OFF_CTL]; // see RULE4

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dep_buf_ff <= 1'b0;
            dep_ctl_ff <= 1'b0;
        end else begin
            dep_buf_ff <= same_region && check_buf_on;
            dep_ctl_ff <= same_region && check_ctl_on;
        end
    end

    assign dep_wait_buffer_unit = dep_buf_ff;
    assign dep_wait_control_unit = dep_ctl_ff;
endmodule // page_dep_check
`default_nettype wire

/* hdl/smmu_aux_config_register.sv */
// Summary of operation
// RULE1: lock bit set makes context aux registers read-only
// RULE2: same 4KB, stream, security waits on walk
// RULE3: buffer-unit dependency check off when bit set
// RULE4: control-unit dependency check off when bit set
// RULE5: software changes dependency defaults only for debug
// RULE6: stream-context bypass info cached when bit set
// RULE7: each cached bypass takes one lookaside entry
// RULE8: translation-off bypass attributes cached when bit set
// RULE9: translation-off bypass hit completes six cycles sooner
// RULE10: walk cache bit non-secure only, others banked
// RULE11: unmatched-stream bypass info cached when bit set
// RULE12: stage 2 walk cache 2 enabled, resets one
// RULE13: reserved bits read zero, writes ignored
`default_nettype none
module smmu_aux_config_register
    import aux_cfg_pkg::*;
#(
    parameter int SID_W = 16,
    parameter int ADDR_W = 48,
    parameter int LAT_MISS = LAT_MISS_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic ctx_aux_wr_en_nonsecure,
    output logic ctx_aux_wr_en_secure,
    output logic stage2_walk_cache2_en,
    input wire logic txn_valid,
    output logic txn_ready,
    input wire logic txn_secure,
    input wire logic [1:0] txn_kind,
    input wire logic txn_bypass_hit,
    input wire logic [SID_W-1:0] txn_stream_identifier,
    input wire logic [ADDR_W-1:0] txn_addr,
    input wire logic walk_active,
    input wire logic walk_secure,
    input wire logic [SID_W-1:0] walk_stream_identifier,
    input wire logic [ADDR_W-1:0] walk_addr,
    output logic dep_wait_buffer_unit,
    output logic dep_wait_control_unit,
    output logic alloc_entry,
    output logic txn_done
);
    aux_cfg_if cfg_bus ();

    logic [31:0] ns_reg_ff;
    logic [31:0] s_reg_ff;
    logic [31:0] nxt_ns_reg;
    logic [31:0] nxt_s_reg;

    logic aw_got_ff;
    logic w_got_ff;
    logic [AXI_AW-1:0] awaddr_ff;
    logic aw_secure_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // ---------------- write channel ----------------
    logic aw_hs;
    logic w_hs;
    logic have_aw;
    logic have_w;
    logic do_write;
    logic [AXI_AW-1:0] wr_addr;
    logic wr_secure;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic wr_ns;
    logic wr_s;

    // one write in flight: no new address or data until the response is taken
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign have_aw = aw_got_ff || aw_hs;
    assign have_w = w_got_ff || w_hs;
    assign do_write = have_aw && have_w;
    assign wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
    // prot[1] low marks a secure access
    assign wr_secure = aw_got_ff ? aw_secure_ff : !s_axi_awprot[1];
    assign wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_hit = (wr_addr[AXI_AW-1:2] == ACR_OFFSET[AXI_AW-1:2]);

    // banked write: the access security picks the copy
    assign wr_ns = do_write && wr_hit && !wr_secure;
    assign wr_s = do_write && wr_hit && wr_secure;
    assign nxt_ns_reg = wr_ns
        ? merge_write(ns_reg_ff, wr_data, wr_strb, NS_WR_MASK) // see RULE13
        : ns_reg_ff;
    assign nxt_s_reg = wr_s
        ? merge_write(s_reg_ff, wr_data, wr_strb, S_WR_MASK) // see RULE10
        : s_reg_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ns_reg_ff <= NS_RESET; // see RULE1
        end else begin
            ns_reg_ff <= nxt_ns_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg_ff <= S_RESET;
        end else begin
            s_reg_ff <= nxt_s_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
        end else if (do_write) begin
            aw_got_ff <= 1'b0;
        end else if (aw_hs) begin
            aw_got_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= '0;
            aw_secure_ff <= 1'b0;
        end else if (aw_hs) begin
            awaddr_ff <= s_axi_awaddr;
            aw_secure_ff <= !s_axi_awprot[1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff <= 1'b0;
        end else if (do_write) begin
            w_got_ff <= 1'b0;
        end else if (w_hs) begin
            w_got_ff <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (w_hs) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // ---------------- read channel ----------------
    logic ar_hs;
    logic rd_hit;
    logic [31:0] rd_word;

    assign s_axi_arready = !rvalid_ff;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign rd_hit = (s_axi_araddr[AXI_AW-1:2] == ACR_OFFSET[AXI_AW-1:2]);
    // reserved bits are never set in either copy, so they read zero
    assign rd_word = !rd_hit ? 32'h0000_0000
        : (!s_axi_arprot[1] ? s_reg_ff : ns_reg_ff); // see RULE10

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (ar_hs) begin
            rdata_ff <= rd_word; // see RULE13
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ---------------- configuration outputs ----------------
    logic ns_lock;
    logic s_lock;
    logic ctx_ns_en_ff;
    logic ctx_s_en_ff;
    logic s2wc_en_ff;

    assign ns_lock = ns_reg_ff[BIT_CTX_LOCK];
    assign s_lock = s_reg_ff[BIT_CTX_LOCK];

    // the secure lock overrides the non-secure one for every context
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctx_ns_en_ff <= 1'b0;
        end else begin
            ctx_ns_en_ff <= !ns_lock && !s_lock; // see RULE1
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctx_s_en_ff <= 1'b0;
        end else begin
            ctx_s_en_ff <= !s_lock;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s2wc_en_ff <= 1'b1;
        end else begin
            s2wc_en_ff <= ns_reg_ff[BIT_S2_WALK_CACHE2]; // see RULE12
        end
    end

    assign ctx_aux_wr_en_nonsecure = ctx_ns_en_ff;
    assign ctx_aux_wr_en_secure = ctx_s_en_ff;
    assign stage2_walk_cache2_en = s2wc_en_ff;

    assign cfg_bus.ns_cfg = ns_reg_ff;
    assign cfg_bus.s_cfg = s_reg_ff;

    // ---------------- consumers of the tuning bits ----------------
    // dependency checking costs latency only while its disable bit is clear
    page_dep_check #(
        .SID_W(SID_W),
        .ADDR_W(ADDR_W)
    ) u_page_dep_check (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg_bus.cfg_snk),
        .txn_valid(txn_valid),
        .txn_secure(txn_secure),
        .txn_stream_identifier(txn_stream_identifier),
        .txn_addr(txn_addr),
        .walk_active(walk_active),
        .walk_secure(walk_secure),
        .walk_stream_identifier(walk_stream_identifier),
        .walk_addr(walk_addr),
        .dep_wait_buffer_unit(dep_wait_buffer_unit),
        .dep_wait_control_unit(dep_wait_control_unit)
    );

    bypass_cache_ctrl #(
        .LAT_MISS(LAT_MISS)
    ) u_bypass_cache_ctrl (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg_bus.cfg_snk),
        .txn_valid(txn_valid),
        .txn_ready(txn_ready),
        .txn_secure(txn_secure),
        .txn_kind(txn_kind),
        .txn_bypass_hit(txn_bypass_hit),
        .alloc_entry(alloc_entry),
        .txn_done(txn_done)
    );
endmodule // smmu_aux_config_register
`default_nettype wire

/* tb/smmu_aux_config_register_asserts.sv */
`default_nettype none
module smmu_aux_config_register_asserts
    import aux_cfg_pkg::*;
#(
    parameter int ADDR_W = 48,
    parameter int LAT_MISS = LAT_MISS_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic txn_valid,
    input wire logic txn_ready,
    input wire logic [1:0] txn_kind,
    input wire logic txn_bypass_hit,
    input wire logic [ADDR_W-1:0] txn_addr,
    input wire logic walk_active,
    input wire logic [ADDR_W-1:0] walk_addr,
    input wire logic dep_wait_buffer_unit,
    input wire logic dep_wait_control_unit,
    input wire logic alloc_entry,
    input wire logic txn_done
);
    localparam int MISS_DONE = LAT_MISS + 1;
    localparam int HIT_DONE = LAT_MISS - 5;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_take;
        txn_valid && txn_ready;
    endsequence
    sequence s_take_hit;
        txn_valid && txn_ready && txn_bypass_hit && txn_kind != TXN_TRANSLATE;
    endsequence
    sequence s_take_miss;
        txn_valid && txn_ready && !(txn_bypass_hit && txn_kind != TXN_TRANSLATE);
    endsequence
    property p_hit_done;
        s_take_hit |-> ##HIT_DONE txn_done;
    endproperty
    a_hit_done: assert property (p_hit_done) else $error("hit done late");
    property p_miss_done;
        s_take_miss |-> ##MISS_DONE txn_done;
    endproperty
    a_miss_done: assert property (p_miss_done) else $error("miss done late");
    property p_busy;
        s_take |=> (!txn_ready && !txn_done)[*3];
    endproperty
    a_busy: assert property (p_busy) else $error("txn port not busy");
    property p_done_pulse;
        txn_done |=> txn_ready && !txn_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    property p_alloc_hit;
        s_take_hit or (s_take and txn_kind == TXN_TRANSLATE) |=> !alloc_entry;
    endproperty
    a_alloc_hit: assert property (p_alloc_hit) else $error("alloc without miss");
    // a walk in a different 4KB page never makes a transaction wait
    property p_dep_page;
        txn_valid && walk_active && txn_addr[ADDR_W-1:12] != walk_addr[ADDR_W-1:12]
            |=> !dep_wait_buffer_unit && !dep_wait_control_unit;
    endproperty
    a_dep_page: assert property (p_dep_page) else $error("wait across pages");
    property p_dep_idle;
        !txn_valid || !walk_active |=> !dep_wait_buffer_unit && !dep_wait_control_unit;
    endproperty
    a_dep_idle: assert property (p_dep_idle) else $error("wait without walk");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during response");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule // smmu_aux_config_register_asserts

bind smmu_aux_config_register smmu_aux_config_register_asserts #(
    .ADDR_W(ADDR_W), .LAT_MISS(LAT_MISS)
) smmu_aux_config_register_asserts_i (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .txn_valid, .txn_ready, .txn_kind, .txn_bypass_hit, .txn_addr,
    .walk_active, .walk_addr, .dep_wait_buffer_unit, .dep_wait_control_unit,
    .alloc_entry, .txn_done
);
`default_nettype wire

/* tb/smmu_aux_config_register_tb.sv */
`default_nettype none
module smmu_aux_config_register_tb
    import aux_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic txn_valid = 1'b0, txn_secure = 1'b0, txn_bypass_hit = 1'b0;
    logic walk_active = 1'b0, walk_secure = 1'b0;
    logic [1:0] txn_kind = 2'h0;
    logic [15:0] txn_stream_identifier = 16'h0000, walk_stream_identifier = 16'h0000;
    logic [47:0] txn_addr = 48'h0000_0000_0000, walk_addr = 48'h0000_0000_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic ctx_aux_wr_en_nonsecure, ctx_aux_wr_en_secure, stage2_walk_cache2_en;
    logic txn_ready, dep_wait_buffer_unit, dep_wait_control_unit, alloc_entry, txn_done;
    logic [1:0] rsp;
    logic [31:0] rd;
    int num_errors = 0;
    int checks = 0;
    // index 0 non-secure copy, 1 secure copy
    logic [31:0] bank_m [2] = '{32'h0400_0008, 32'h0400_0000};

    always #12.5 aclk = ~aclk;

    smmu_aux_config_register #(.LAT_MISS(LAT)) smmu_aux_config_register_i (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .ctx_aux_wr_en_nonsecure, .ctx_aux_wr_en_secure, .stage2_walk_cache2_en,
        .txn_valid, .txn_ready, .txn_secure, .txn_kind, .txn_bypass_hit,
        .txn_stream_identifier, .txn_addr, .walk_active, .walk_secure,
        .walk_stream_identifier, .walk_addr, .dep_wait_buffer_unit,
        .dep_wait_control_unit, .alloc_entry, .txn_done
    );

    task automatic finish_test();
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_up();
        chk("timeout", 32'h0000_0001, 32'h0000_0000);
        finish_test();
    endtask

    // ready is looked at on the falling edge so the rising edge acts on settled values
    task automatic axi_wr(input logic [15:0] a, input logic [2:0] p, input logic [31:0] d,
                          input logic [3:0] st, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        int n;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_awprot <= p;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_bready <= 1'b1;
        n = 0;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            n++;
            if (n > 50) give_up();
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [15:0] a, input logic [2:0] p, output logic [31:0] d,
                          output logic [1:0] r);
        logic ar_t, r_t;
        int n;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_arprot <= p;
        s_axi_rready <= 1'b1;
        n = 0;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            n++;
            if (n > 50) give_up();
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic reg_wr(input bit sec, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] m;
        m = sec ? 32'h0700_0700 : 32'h0700_0708;
        for (int i = 0; i < 4; i++) begin
            if (!st[i]) m[i*8 +: 8] = 8'h00;
        end
        axi_wr(16'h0010, {1'b0, !sec, 1'b0}, d, st, rsp);
        chk("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        bank_m[sec] = (d & m) | (bank_m[sec] & ~m);
    endtask

    task automatic reg_chk(input bit sec);
        axi_rd(16'h0010, {1'b0, !sec, 1'b0}, rd, rsp);
        chk("rresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
        chk("readback", rd, bank_m[sec]);
        @(negedge aclk);
        chk("wr_en_ns", ctx_aux_wr_en_nonsecure, !bank_m[0][26] && !bank_m[1][26]);
        chk("wr_en_s", ctx_aux_wr_en_secure, !bank_m[1][26]);
        chk("walk_cache2", stage2_walk_cache2_en, bank_m[0][3]);
    endtask

    task automatic txn_run(input logic [1:0] k, input bit hit, input bit sec);
        logic [47:0] a, wa;
        logic [15:0] wsid;
        logic [31:0] b;
        bit wsec, match, alc;
        int lat, n;
        a = 48'({$urandom(), $urandom()});
        wa = ($urandom() % 2) ? {a[47:12], 12'($urandom())} : a ^ 48'h0000_0000_1000;
        wsid = ($urandom() % 4 == 0) ? 16'h0001 : 16'h0000;
        wsec = ($urandom() % 4 == 0) ? !sec : sec;
        b = bank_m[sec];
        match = a[47:12] == wa[47:12] && wsid == 16'h0000 && wsec == sec;
        lat = (hit && k != 2'b00) ? LAT - 6 + 1 : LAT + 1;
        alc = k != 2'b00 && !hit && b[k == 2'b01 ? 10 : (k == 2'b11 ? 9 : 8)];
        @(posedge aclk);
        txn_valid <= 1'b1;
        txn_kind <= k;
        txn_bypass_hit <= hit;
        txn_secure <= sec;
        txn_stream_identifier <= 16'h0000;
        txn_addr <= a;
        walk_active <= 1'b1;
        walk_secure <= wsec;
        walk_stream_identifier <= wsid;
        walk_addr <= wa;
        @(negedge aclk);
        chk("txn_ready", txn_ready, 32'h0000_0001);
        @(posedge aclk);
        txn_valid <= 1'b0;
        walk_active <= 1'b0;
        @(negedge aclk);
        chk("dep_buf", dep_wait_buffer_unit, match && !b[25]);
        chk("dep_ctl", dep_wait_control_unit, match && !b[24]);
        chk("alloc", alloc_entry, alc);
        n = 1;
        while (txn_done !== 1'b1 && n < 40) begin
            @(negedge aclk);
            n++;
        end
        if (txn_done !== 1'b1) give_up();
        chk("latency", n, lat);
    endtask

    initial begin
        void'($urandom(64));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        reg_chk(0);
        reg_chk(1);
        axi_wr(16'h0014, 3'b010, 32'hffff_ffff, 4'hf, rsp);
        chk("bresp_unmapped", {30'h0, rsp}, {30'h0, RESP_DECERR});
        axi_rd(16'h0014, 3'b010, rd, rsp);
        chk("rresp_unmapped", {30'h0, rsp}, {30'h0, RESP_DECERR});
        reg_chk(0);
        reg_wr(0, 32'hffff_ffff, 4'hf);
        reg_wr(1, 32'hffff_ffff, 4'hf);
        reg_chk(0);
        reg_chk(1);
        // random contents keep lock, disable and cache bits moving under traffic
        repeat (40) begin
            reg_wr(1'($urandom()), $urandom(), 4'($urandom()));
            reg_chk(0);
            reg_chk(1);
            for (int k = 0; k < 4; k++) begin
                txn_run(2'(k), 1'($urandom()), 1'($urandom()));
            end
        end
        finish_test();
    end
endmodule // smmu_aux_config_register_tb
`default_nettype wire
